// file: tws_slave.sv
// two-wire slave port toward an internal register file
`timescale 1ns/10ps
`default_nettype none
module tws_slave
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        hw_reset_n,
	// bus
	tws_bus_if.slave         bus,
	// register file side
	output var logic         regWrStb_q,
	output var logic [7:0]   regAddr_q,
	output var logic [7:0]   regWrData_q,
	output var logic         regRdReq_q,
	input  wire logic [7:0]  regRdData,
	output var logic         busBusy_q
);
	// ----------------------------------------
	// synchronise and filter
	// ----------------------------------------
	logic [1:0] sclSync_q;
	logic [1:0] sdaSync_q;
	logic [tws_pkg::FILT_LEN-1:0] sclHist_q;
	logic [tws_pkg::FILT_LEN-1:0] sdaHist_q;
	logic sclF_q;
	logic sdaF_q;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic portRst;

	assign portRst = ~hw_reset_n | ~rst_n;

	function automatic logic filt(input logic [tws_pkg::FILT_LEN-1:0] h, input logic cur);
		filt = (&h) ? 1'b1 : ((|h) ? cur : 1'b0);
	endfunction : filt

	always_ff @(posedge clock or negedge hw_reset_n)
	begin
		if (!hw_reset_n)
		begin
			sclSync_q <= 2'h3;
			sdaSync_q <= 2'h3;
			sclHist_q <= '1;
			sdaHist_q <= '1;
			sclF_q    <= 1'b1;
			sdaF_q    <= 1'b1;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end
		else
		begin
			sclSync_q <= {sclSync_q[0], bus.scl};
			sdaSync_q <= {sdaSync_q[0], bus.sda};
			sclHist_q <= {sclHist_q[tws_pkg::FILT_LEN-2:0], sclSync_q[1]};
			sdaHist_q <= {sdaHist_q[tws_pkg::FILT_LEN-2:0], sdaSync_q[1]};
			sclF_q    <= filt(sclHist_q, sclF_q);
			sdaF_q    <= filt(sdaHist_q, sdaF_q);
			sclPrev_q <= sclF_q;
			sdaPrev_q <= sdaF_q;
		end
	end

	logic startDet;
	logic stopDet;
	logic sclRise;
	logic sclFall;
	assign startDet = sclF_q & sclPrev_q & sdaPrev_q & ~sdaF_q;
	assign stopDet  = sclF_q & sclPrev_q & ~sdaPrev_q & sdaF_q;
	assign sclRise  = sclF_q & ~sclPrev_q;
	assign sclFall  = ~sclF_q & sclPrev_q;

	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	tws_pkg::tws_state_t state_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q;
	logic       ackPend_q;
	logic       sdaLow_q;
	logic [7:0] txByte_q;

	always_ff @(posedge clock or negedge hw_reset_n)
	begin
		if (!hw_reset_n)
		begin
			state_q     <= tws_pkg::TWS_IDLE;
			bitCnt_q    <= tws_pkg::BIT_ZERO;
			shift_q     <= 8'h00;
			ackPend_q   <= 1'b0;
			sdaLow_q    <= 1'b0;
			txByte_q    <= 8'h00;
			regWrStb_q  <= 1'b0;
			regAddr_q   <= 8'h00;
			regWrData_q <= 8'h00;
			regRdReq_q  <= 1'b0;
		end
		else if (portRst)
		begin
			state_q    <= tws_pkg::TWS_IDLE;
			bitCnt_q   <= tws_pkg::BIT_ZERO;
			ackPend_q  <= 1'b0;
			sdaLow_q   <= 1'b0;
			regWrStb_q <= 1'b0;
			regRdReq_q <= 1'b0;
		end
		else
		begin
			regWrStb_q <= 1'b0;
			regRdReq_q <= 1'b0;
			if (startDet)
			begin
				state_q   <= tws_pkg::TWS_ADDR;
				// first scl fall after start carries no bit
				bitCnt_q  <= tws_pkg::BIT_ARMED;
				ackPend_q <= 1'b0;
				sdaLow_q  <= 1'b0;
			end
			else if (stopDet)
			begin
				state_q  <= tws_pkg::TWS_IDLE;
				sdaLow_q <= 1'b0;
			end
			else if (sclRise && state_q != tws_pkg::TWS_IDLE && state_q != tws_pkg::TWS_WAIT)
			begin
				if (bitCnt_q == tws_pkg::ACK_BIT)
				begin
					// master ack after read byte; nack ends reading
					if (state_q == tws_pkg::TWS_RDAT && sdaF_q)
						state_q <= tws_pkg::TWS_WAIT;
				end
				else
					shift_q <= {shift_q[6:0], sdaF_q};
			end
			else if (sclFall && state_q != tws_pkg::TWS_IDLE && state_q != tws_pkg::TWS_WAIT)
			begin
				if (bitCnt_q == tws_pkg::ACK_BIT)
				begin
					bitCnt_q <= tws_pkg::BIT_ZERO;
					if (ackPend_q)
					begin
						ackPend_q <= 1'b0;
						if (state_q == tws_pkg::TWS_RDAT)
							sdaLow_q <= ~txByte_q[7];
						else
							sdaLow_q <= 1'b0;
					end
					else if (state_q == tws_pkg::TWS_RDAT)
						sdaLow_q <= ~txByte_q[7];
					else
						sdaLow_q <= 1'b0;
				end
				else if (bitCnt_q == 4'h7)
				begin
					bitCnt_q <= tws_pkg::ACK_BIT;
					case (state_q)
						tws_pkg::TWS_ADDR:
						begin
							if (shift_q[7:1] == tws_pkg::SLAVE_ADDR)
							begin
								ackPend_q <= 1'b1;
								sdaLow_q  <= 1'b1;
								if (shift_q[0])
								begin
									state_q    <= tws_pkg::TWS_RDAT;
									txByte_q   <= regRdData;
								end
								else
									state_q <= tws_pkg::TWS_REG;
							end
							else
							begin
								state_q  <= tws_pkg::TWS_WAIT;
								sdaLow_q <= 1'b0;
							end
						end
						tws_pkg::TWS_REG:
						begin
							regAddr_q  <= shift_q;
							regRdReq_q <= 1'b1;
							sdaLow_q   <= 1'b1;
							ackPend_q  <= 1'b1;
							state_q    <= tws_pkg::TWS_WDAT;
						end
						tws_pkg::TWS_WDAT:
						begin
							regWrData_q <= shift_q;
							regWrStb_q  <= 1'b1;
							sdaLow_q    <= 1'b1;
							ackPend_q   <= 1'b1;
						end
						tws_pkg::TWS_RDAT:
							sdaLow_q <= 1'b0;
						default:
							sdaLow_q <= 1'b0;
					endcase
				end
				else
				begin
					bitCnt_q <= bitCnt_q + 4'h1;
					if (state_q == tws_pkg::TWS_RDAT)
					begin
						txByte_q <= {txByte_q[6:0], 1'b0};
						sdaLow_q <= ~txByte_q[6];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// busy flag and pin drive
	// ----------------------------------------
	always_ff @(posedge clock or negedge hw_reset_n)
	begin
		if (!hw_reset_n)
			busBusy_q <= 1'b0;
		else if (portRst || stopDet)
			busBusy_q <= 1'b0;
		else if (startDet)
			busBusy_q <= 1'b1;
	end

	assign bus.sdaSlvOut  = 1'b0;
	assign bus.sdaSlvOe_n = ~sdaLow_q;
endmodule : tws_slave
`default_nettype wire

// file: tws_pkg.sv
// constants and types shared by both ends of the two-wire register port
// Contract
// - SDA falls while SCL high: start
// - SDA rises while SCL high: stop
// - repeated start restarts address reception
// - bus busy from start until stop
// - SDA stable while SCL high
// - master makes every clock pulse
// - slave drives only ack or read data
// - master shifts on fall, samples on rise
// - eight bits MSB first, then ack
// - receiver acks by pulling SDA low
// - master stops or restarts after nack
// - master nacks last read byte
// - master clocks the ninth pulse
// - first byte: address and direction bit
// - match acks and sets direction; else silent
// - bus address is 0x74 only
// - write: address, register, data, stop
// - read: register, repeated start, read data
// - master nacks read byte then stops
// - slave only, up to 100 kbit/s
// - slave drives low or releases only
// - reset clears port, held at least 1 us
package tws_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h74;
	localparam int CLK_HZ = 40000000;
	localparam int SCL_HZ = 100000;
	localparam int HALF_CYC = CLK_HZ / SCL_HZ / 2;
	localparam int FILT_LEN = 3;
	localparam int RESET_NS = 1000;
	localparam int RESET_CYC = (RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ARMED = 4'hF;

	typedef enum logic [2:0]
	{
		TWS_IDLE = 3'b000,
		TWS_ADDR = 3'b001,
		TWS_REG  = 3'b011,
		TWS_WDAT = 3'b010,
		TWS_RDAT = 3'b110,
		TWS_WAIT = 3'b111
	} tws_state_t;

	typedef enum logic [2:0]
	{
		TWM_IDLE  = 3'b000,
		TWM_START = 3'b001,
		TWM_BIT   = 3'b011,
		TWM_STOP  = 3'b010,
		TWM_DONE  = 3'b110
	} twm_state_t;
endpackage : tws_pkg

// file: tws_bus_if.sv
// two-wire bus with pull-ups resolving open-drain drivers
`timescale 1ns/10ps
`default_nettype none
interface tws_bus_if;
	logic sclOe_n;
	logic sdaMstOut;
	logic sdaMstOe_n;
	logic sdaSlvOut;
	logic sdaSlvOe_n;
	logic scl;
	logic sda;
	assign scl = sclOe_n;
	assign sda = (sdaMstOe_n | sdaMstOut) & (sdaSlvOe_n | sdaSlvOut);
	modport master (output sclOe_n, output sdaMstOut, output sdaMstOe_n, input scl, input sda);
	modport slave (output sdaSlvOut, output sdaSlvOe_n, input scl, input sda);
endinterface : tws_bus_if
`default_nettype wire

// file: tws_master.sv
// two-wire master issuing register byte writes and reads
`timescale 1ns/10ps
`default_nettype none
module tws_master
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// bus
	tws_bus_if.master        bus,
	// user command
	input  wire logic        cmdValid,
	input  wire logic        cmdRead,
	input  wire logic [7:0]  cmdReg,
	input  wire logic [7:0]  cmdData,
	output var logic         cmdBusy_q,
	output var logic         cmdDone_q,
	output var logic         cmdNack_q,
	output var logic [7:0]   rdData_q
);
	// ----------------------------------------
	// sampled inputs
	// ----------------------------------------
	logic [1:0] sdaSync_q;
	always_ff @(posedge clock)
		if (!rst_n)
			sdaSync_q <= 2'h3;
		else
			sdaSync_q <= {sdaSync_q[0], bus.sda};

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	tws_pkg::twm_state_t state_q;
	logic [9:0] tick_q;
	logic [1:0] phase_q;
	logic [3:0] bitCnt_q;
	logic [2:0] byteIdx_q;
	logic [7:0] txByte_q;
	logic [7:0] rxByte_q;
	logic       read_q;
	logic       sclHi_q;
	logic       sdaHi_q;
	logic       tick;

	assign tick = (tick_q == 10'(tws_pkg::HALF_CYC - 1));

	function automatic logic [7:0] byteFor(input logic [2:0] idx, input logic rd,
		input logic [7:0] rg, input logic [7:0] dt);
		case (idx)
			3'h0: byteFor = {tws_pkg::SLAVE_ADDR, 1'b0};
			3'h1: byteFor = rg;
			3'h2: byteFor = rd ? {tws_pkg::SLAVE_ADDR, 1'b1} : dt;
			default: byteFor = 8'hFF;
		endcase
	endfunction : byteFor

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_q   <= tws_pkg::TWM_IDLE;
			tick_q    <= 10'h000;
			phase_q   <= 2'h0;
			bitCnt_q  <= 4'h0;
			byteIdx_q <= 3'h0;
			txByte_q  <= 8'h00;
			rxByte_q  <= 8'h00;
			read_q    <= 1'b0;
			sclHi_q   <= 1'b1;
			sdaHi_q   <= 1'b1;
			cmdBusy_q <= 1'b0;
			cmdDone_q <= 1'b0;
			cmdNack_q <= 1'b0;
			rdData_q  <= 8'h00;
		end
		else
		begin
			cmdDone_q <= 1'b0;
			tick_q    <= tick ? 10'h000 : tick_q + 10'h001;
			case (state_q)
				tws_pkg::TWM_IDLE:
				begin
					if (cmdValid)
					begin
						state_q   <= tws_pkg::TWM_START;
						read_q    <= cmdRead;
						byteIdx_q <= 3'h0;
						txByte_q  <= byteFor(3'h0, cmdRead, cmdReg, cmdData);
						cmdBusy_q <= 1'b1;
						cmdNack_q <= 1'b0;
						phase_q   <= 2'h0;
						tick_q    <= 10'h000;
					end
				end
				tws_pkg::TWM_START:
					if (tick)
					begin
						phase_q <= phase_q + 2'h1;
						case (phase_q)
							2'h0:
							begin
								sclHi_q <= 1'b1;
								sdaHi_q <= 1'b1;
							end
							2'h1: sdaHi_q <= 1'b0;
							default:
							begin
								sclHi_q  <= 1'b0;
								phase_q  <= 2'h0;
								bitCnt_q <= 4'h0;
								state_q  <= tws_pkg::TWM_BIT;
							end
						endcase
					end
				tws_pkg::TWM_BIT:
					if (tick)
					begin
						phase_q <= phase_q + 2'h1;
						case (phase_q)
							2'h0: // low half: change data
								if (bitCnt_q == 4'h8)
									sdaHi_q <= 1'b1;
								else if (read_q && byteIdx_q == 3'h3)
									sdaHi_q <= 1'b1;
								else
									sdaHi_q <= txByte_q[7];
							2'h1: sclHi_q <= 1'b1;
							2'h2: // high: sample
								if (bitCnt_q == 4'h8)
								begin
									if (!(read_q && byteIdx_q == 3'h3) && sdaSync_q[1])
										cmdNack_q <= 1'b1;
								end
								else
									rxByte_q <= {rxByte_q[6:0], sdaSync_q[1]};
							default:
							begin
								sclHi_q <= 1'b0;
								phase_q <= 2'h0;
								// release before the slave acks
								if (bitCnt_q == 4'h7)
									sdaHi_q <= 1'b1;
								if (bitCnt_q == 4'h8)
								begin
									bitCnt_q <= 4'h0;
									byteIdx_q <= byteIdx_q + 3'h1;
									txByte_q <= byteFor(byteIdx_q + 3'h1, read_q, cmdReg, cmdData);
									if (cmdNack_q || byteIdx_q == 3'h3 || (!read_q && byteIdx_q == 3'h2))
										state_q <= tws_pkg::TWM_STOP;
									else if (read_q && byteIdx_q == 3'h1)
										state_q <= tws_pkg::TWM_START;
								end
								else
								begin
									bitCnt_q <= bitCnt_q + 4'h1;
									txByte_q <= {txByte_q[6:0], 1'b1};
								end
							end
						endcase
					end
				tws_pkg::TWM_STOP:
					if (tick)
					begin
						phase_q <= phase_q + 2'h1;
						case (phase_q)
							2'h0: sdaHi_q <= 1'b0;
							2'h1: sclHi_q <= 1'b1;
							default:
							begin
								sdaHi_q <= 1'b1;
								phase_q <= 2'h0;
								state_q <= tws_pkg::TWM_DONE;
							end
						endcase
					end
				tws_pkg::TWM_DONE:
					if (tick)
					begin
						if (read_q && !cmdNack_q)
							rdData_q <= rxByte_q;
						cmdDone_q <= 1'b1;
						cmdBusy_q <= 1'b0;
						state_q   <= tws_pkg::TWM_IDLE;
					end
				default:
					state_q <= tws_pkg::TWM_IDLE;
			endcase
		end
	end

	assign bus.sclOe_n    = sclHi_q;
	assign bus.sdaMstOut  = 1'b0;
	assign bus.sdaMstOe_n = sdaHi_q;
endmodule : tws_master
`default_nettype wire

// file: tws_asserts.sv
// concurrent checks on the two-wire bus and both ends
`timescale 1ns/10ps
`default_nettype none
module tws_asserts
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hw_reset_n,
	// bus
	input wire logic scl,
	input wire logic sda,
	input wire logic sdaMstOe_n,
	input wire logic sdaSlvOut,
	input wire logic sdaSlvOe_n,
	// end status
	input wire logic busBusy_q,
	input wire logic regWrStb_q,
	input wire logic regRdReq_q,
	input wire logic cmdBusy_q,
	input wire logic cmdDone_q
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n || !hw_reset_n);
	AST_SLV_LOW: assert property (sdaSlvOut == 1'h0)
		else $error("slave drives sda high");
	AST_SLV_STABLE: assert property (scl && $past(scl) |-> $stable(sdaSlvOe_n))
		else $error("slave sda moved while scl high");
	AST_NO_CLASH: assert property (!sdaSlvOe_n |-> sdaMstOe_n)
		else $error("slave drives while master drives");
	AST_SLV_IDLE: assert property (!busBusy_q |-> sdaSlvOe_n)
		else $error("slave drives on idle bus");
	AST_START: assert property (scl && $fell(sda) |-> ##[1:8] busBusy_q)
		else $error("start not seen");
	AST_STOP: assert property (scl && $rose(sda) |-> ##[1:8] !busBusy_q)
		else $error("stop not seen");
	AST_BUSY_HOLD: assert property ($fell(busBusy_q) |-> scl && sda)
		else $error("busy dropped without stop");
	AST_WR_STB: assert property (regWrStb_q |-> !scl && busBusy_q ##1 !regWrStb_q)
		else $error("bad write strobe");
	AST_RD_REQ: assert property (regRdReq_q |-> !scl ##1 !regRdReq_q)
		else $error("bad read request");
	AST_DONE: assert property (cmdDone_q |-> scl && sda ##1 !cmdDone_q)
		else $error("done without released bus");
	AST_IDLE_HIGH: assert property (!cmdBusy_q && !busBusy_q |-> scl && sda)
		else $error("idle bus not high");
endmodule : tws_asserts
`default_nettype wire

// file: tb_top.sv
// self-checking bench joining master and slave ends
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clock = 1'h0;
	logic        rst_n = 1'h0;
	logic        hwReset_n = 1'h0;
	logic        cmdValid = 1'h0;
	logic        cmdRead = 1'h0;
	logic [7:0]  cmdReg = 8'h00;
	logic [7:0]  cmdData = 8'h00;
	logic        cmdBusy_q, cmdDone_q, cmdNack_q, regWrStb_q, regRdReq_q, busBusy_q;
	logic [7:0]  rdData_q, regAddr_q, regWrData_q, regRdData;
	logic [7:0]  mem [256];
	logic [37:0] bitSh;
	logic [31:0] rnd = 32'hAD5266D4;
	int          bitCnt, wrCnt, rdReqCnt, cyc, error_cnt, tests_run;
	tws_bus_if bus ();
	tws_master tws_master_i (.clock(clock), .rst_n(rst_n), .bus(bus), .cmdValid(cmdValid),
		.cmdRead(cmdRead), .cmdReg(cmdReg), .cmdData(cmdData), .cmdBusy_q(cmdBusy_q),
		.cmdDone_q(cmdDone_q), .cmdNack_q(cmdNack_q), .rdData_q(rdData_q));
	tws_slave tws_slave_i (.clock(clock), .rst_n(rst_n), .hw_reset_n(hwReset_n), .bus(bus),
		.regWrStb_q(regWrStb_q), .regAddr_q(regAddr_q), .regWrData_q(regWrData_q),
		.regRdReq_q(regRdReq_q), .regRdData(regRdData), .busBusy_q(busBusy_q));
	tws_asserts tws_asserts_i (.clock(clock), .rst_n(rst_n), .hw_reset_n(hwReset_n),
		.scl(bus.scl), .sda(bus.sda), .sdaMstOe_n(bus.sdaMstOe_n), .sdaSlvOut(bus.sdaSlvOut),
		.sdaSlvOe_n(bus.sdaSlvOe_n), .busBusy_q(busBusy_q), .regWrStb_q(regWrStb_q),
		.regRdReq_q(regRdReq_q), .cmdBusy_q(cmdBusy_q), .cmdDone_q(cmdDone_q));
	// ----------------------------------------
	// clock, register file model, wire monitor
	// ----------------------------------------
	always #12.5 clock = ~clock;
	assign regRdData = mem[regAddr_q];
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (regWrStb_q === 1'h1)
		begin
			mem[regAddr_q] <= regWrData_q;
			wrCnt <= wrCnt + 1;
		end
		if (regRdReq_q === 1'h1)
			rdReqCnt <= rdReqCnt + 1;
		if (cyc == 100000)
		begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			print_verdict();
		end
	end
	always @(posedge bus.scl)
	begin
		bitSh = {bitSh[36:0], bus.sda};
		bitCnt++;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [37:0] expBits(input logic rd, input logic [7:0] rg,
		input logic [7:0] dt);
		// scl also rises for the repeated start and for the stop
		if (rd)
			return {tws_pkg::SLAVE_ADDR, 2'h0, rg, 2'h1, tws_pkg::SLAVE_ADDR, 2'h2, dt, 2'h2};
		return {10'h000, tws_pkg::SLAVE_ADDR, 2'h0, rg, 1'h0, dt, 2'h0};
	endfunction : expBits
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'h1)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic xfer(input logic rd, input logic [7:0] rg, input logic [7:0] dt);
		int n;
		int rq;
		n = 0;
		rq = rdReqCnt;
		@(posedge clock);
		bitSh = 38'h0;
		bitCnt = 0;
		cmdValid <= 1'h1;
		cmdRead <= rd;
		cmdReg <= rg;
		cmdData <= dt;
		@(negedge clock);
		while (cmdBusy_q !== 1'h1 && n < 10)
		begin
			@(negedge clock);
			n++;
		end
		@(posedge clock) cmdValid <= 1'h0;
		while (cmdDone_q !== 1'h1 && n < 40000)
		begin
			@(negedge clock);
			n++;
		end
		chk(cmdDone_q === 1'h1, "no done");
		chk(cmdNack_q === 1'h0, "byte not acked");
		chk(bitCnt == (rd ? 38 : 28), "clock pulse count");
		chk(rdReqCnt == rq + 1 && regAddr_q === rg, "register address phase");
		chk(busBusy_q === 1'h0, "bus not freed");
		chk(bitSh === expBits(rd, rg, dt), "wire bit sequence");
	endtask : xfer
	task automatic print_verdict();
		$display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [7:0] r;
		logic [7:0] d;
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		repeat (35) @(posedge clock);
		hwReset_n <= 1'h1;
		repeat (8) @(negedge clock);
		chk(busBusy_q === 1'h0 && regWrStb_q === 1'h0, "reset state");
		$display("test reset done");
		rnd = lfsr(rnd);
		r = rnd[7:0];
		rnd = lfsr(rnd);
		d = rnd[15:8];
		xfer(1'h0, r, d);
		chk(wrCnt == 1 && mem[r] === d, "register write");
		$display("test write done");
		xfer(1'h1, r, d);
		chk(rdData_q === d, "register read");
		$display("test read done");
		xfer(1'h0, 8'hFF, 8'h00);
		chk(wrCnt == 2 && mem[8'hFF] === 8'h00, "back to back write");
		$display("test corner write done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
